// ---- hw/hb8_consts.svh ----
/*
 * Constants for the eight_bit_host_bus master: mode codes, select options
 * and phase times. Assumes a 125 MHz clk_sys (8 ns period).
 */
`ifndef HB8_CONSTS_SVH
`define HB8_CONSTS_SVH

// Mode field codes
`define HB8_PORT_MODE_HB8   4'h2
`define HB8_HB_MODE_MUXED   2'h0
`define HB8_HB_MODE_NONMUX  2'h1

// select_latch_config codes
`define HB8_SEL_ALE_ONLY    2'h0
`define HB8_SEL_ONE_CS      2'h1
`define HB8_SEL_TWO_CS      2'h2
`define HB8_SEL_ALE_TWO_CS  2'h3

// Phase times in ns; slow on purpose so old logic keeps up
`define HB8_CLK_NS          8
`define HB8_T_ADDR_NS       24
`define HB8_T_STROBE_NS     48
`define HB8_T_RECOV_NS      16

// Least times round up to whole cycles
`define HB8_CYC(ns)         (((ns) + `HB8_CLK_NS - 1) / `HB8_CLK_NS)

// Field widths and positions
`define HB8_LO_W            8
`define HB8_HI_W            12
`define HB8_ADDR_W          20
`define HB8_HI_LSB          8
`define HB8_CNT_W           4

`endif

// ---- hw/hb8_mux_bus.sv ----
/*
 * Master for the 8-bit host bus with shared address/data lines, plus the
 * dedicated-pin variant. Config fields arrive as plain inputs.
 * Assumes one access at a time from the user side; shared-line inputs
 * come from pins and are synchronised here.
 */
`timescale 1ns/100ps
`include "hb8_consts.svh"

// Summary of operation
// - Bus runs only when port mode is 0x2
// - Host mode 0x0 selects shared address/data
// - Lines 0-7 carry address, then data
// - Lines 8-19 carry address bits 8-19
// - Strobe latch; external latch holds address
// - Separate read and write data strobes
// - Up to two chip selects available
// - Select config picks latch and select pins
// - Slow phase timing for older logic
// - Host mode 0x1 uses dedicated address pins
module hb8_mux_bus #(
    parameter int ADDR_CYCLES   = `HB8_CYC(`HB8_T_ADDR_NS),
    parameter int STROBE_CYCLES = `HB8_CYC(`HB8_T_STROBE_NS),
    parameter int RECOV_CYCLES  = `HB8_CYC(`HB8_T_RECOV_NS)
) (
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    // Configuration fields
    input  wire logic [3:0]             port_mode,
    input  wire logic [1:0]             host_bus_mode,
    input  wire logic [1:0]             select_latch_config,
    // Access request
    input  wire logic                   req_valid,
    output logic                        req_ready,
    input  wire logic                   req_write,
    input  wire logic                   req_sel,
    input  wire logic [`HB8_ADDR_W-1:0] req_addr,
    input  wire logic [`HB8_LO_W-1:0]   req_wdata,
    // Access answer
    output logic                        rsp_valid,
    output logic [`HB8_LO_W-1:0]        rsp_rdata,
    // Shared lines 0-7
    input  wire logic [`HB8_LO_W-1:0]   shared_line_in,
    output logic [`HB8_LO_W-1:0]        shared_line_out,
    output logic [`HB8_LO_W-1:0]        shared_line_oe,
    // Dedicated address lines 8-19
    output logic [`HB8_HI_W-1:0]        addr_line,
    // Strobes and selects
    output logic                        latch_or_sel0,
    output logic                        sel0_alt_n,
    output logic                        sel1_n,
    output logic                        rd_n,
    output logic                        wr_n
);
    import hb8_pkg::*;

    hb8_state_t                state;       // Sequencer state
    hb8_state_t                next_state;  // Next sequencer state
    logic [`HB8_ADDR_W-1:0]    addr_q;      // Held address
    logic [`HB8_LO_W-1:0]      wdata_q;     // Held write data
    logic                      write_q;     // Held direction
    logic                      sel_q;       // Held peripheral choice
    logic [`HB8_LO_W-1:0]      sync1;       // First sync stage
    logic [`HB8_LO_W-1:0]      sync2;       // Second sync stage
    logic [`HB8_LO_W-1:0]      sync3;       // Third sync stage
    logic [`HB8_LO_W-1:0]      stable_in;   // Last agreed input
    logic                      port_active; // Bus mode enabled
    logic                      muxed;       // Shared-line variant
    logic                      busy;        // Access in flight
    logic                      sel_now;     // Peripheral choice for this cycle

    hb8_tmr_if tmr_bus ();

    hb8_phase_timer u_timer (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .tmr     (tmr_bus.tmr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode of select options, used by several pins
    function automatic logic sel_has_latch(input logic [1:0] cfg);
        return (cfg == `HB8_SEL_ALE_ONLY) || (cfg == `HB8_SEL_ALE_TWO_CS);
    endfunction

    function automatic logic sel_has_two(input logic [1:0] cfg);
        return (cfg == `HB8_SEL_TWO_CS) || (cfg == `HB8_SEL_ALE_TWO_CS);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Mode qualification
    assign port_active = (port_mode == `HB8_PORT_MODE_HB8) &&
                         ((host_bus_mode == `HB8_HB_MODE_MUXED) ||
                          (host_bus_mode == `HB8_HB_MODE_NONMUX));
    assign muxed       = (host_bus_mode == `HB8_HB_MODE_MUXED);
    assign busy        = (state != HB8_IDLE);
    assign req_ready   = port_active && !busy;
    // Held choice lands one edge late, so the take cycle reads the request
    assign sel_now     = (state == HB8_IDLE) ? req_sel : sel_q;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: address, latch release, data strobe, recovery
    always_comb begin
        next_state   = state;
        tmr_bus.load = 1'b0;
        tmr_bus.len  = '0;
        unique case (state)
            HB8_IDLE: begin
                if (req_valid && req_ready) begin
                    next_state   = HB8_ADDR;
                    tmr_bus.load = 1'b1;
                    tmr_bus.len  = hb8_cnt_t'(ADDR_CYCLES - 1);
                end
            end
            HB8_ADDR: begin
                if (tmr_bus.done) begin
                    next_state = HB8_LATCH;
                end
            end
            HB8_LATCH: begin
                // One cycle of hold after the latch closes
                next_state   = HB8_DATA;
                tmr_bus.load = 1'b1;
                tmr_bus.len  = hb8_cnt_t'(STROBE_CYCLES - 1);
            end
            HB8_DATA: begin
                if (tmr_bus.done) begin
                    next_state   = HB8_RECOV;
                    tmr_bus.load = 1'b1;
                    tmr_bus.len  = hb8_cnt_t'(RECOV_CYCLES - 1);
                end
            end
            HB8_RECOV: begin
                if (tmr_bus.done) begin
                    next_state = HB8_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= HB8_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request capture; held for the whole access
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            addr_q  <= '0;
            wdata_q <= '0;
            write_q <= 1'b0;
            sel_q   <= 1'b0;
        end else if (req_valid && req_ready) begin
            addr_q  <= req_addr;
            wdata_q <= req_wdata;
            write_q <= req_write;
            sel_q   <= req_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Three-stage pin sync; accept a value once stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sync1     <= '0;
            sync2     <= '0;
            sync3     <= '0;
            stable_in <= '0;
        end else begin
            sync1 <= shared_line_in;
            sync2 <= sync1;
            sync3 <= sync2;
            if (sync2 == sync3) begin
                stable_in <= sync3;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read answer; sampled on the last strobe cycle, pulse one cycle later
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= (state == HB8_DATA) && tmr_bus.done;
            if ((state == HB8_DATA) && tmr_bus.done && !write_q) begin
                rsp_rdata <= stable_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared lines: address first, then write data or released for read
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            shared_line_out <= '0;
            shared_line_oe  <= '0;
        end else if (muxed && (next_state == HB8_ADDR || next_state == HB8_LATCH)) begin
            shared_line_out <= addr_q[`HB8_LO_W-1:0];
            shared_line_oe  <= '1;
            if (state == HB8_IDLE) begin
                shared_line_out <= req_addr[`HB8_LO_W-1:0];
            end
        end else if (next_state != HB8_IDLE && port_active) begin
            // Data and recovery phases, and the whole access in the dedicated variant
            shared_line_out <= (state == HB8_IDLE) ? req_wdata : wdata_q;
            shared_line_oe  <= {`HB8_LO_W{(state == HB8_IDLE) ? req_write : write_q}};
        end else begin
            shared_line_out <= '0;
            shared_line_oe  <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Dedicated address lines; wider reach when low bits share the lines
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            addr_line <= '0;
        end else if (req_valid && req_ready) begin
            addr_line <= muxed ? req_addr[`HB8_ADDR_W-1:`HB8_HI_LSB]
                               : req_addr[`HB8_HI_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobes, latch and selects; read and write never overlap
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_n          <= 1'b1;
            wr_n          <= 1'b1;
            latch_or_sel0 <= 1'b0;
            sel0_alt_n    <= 1'b0;
            sel1_n        <= 1'b0;
        end else begin
            rd_n <= !((next_state == HB8_DATA) && !write_q);
            wr_n <= !((next_state == HB8_DATA) && write_q);
            // Latch open only during the address phase
            if (sel_has_latch(select_latch_config)) begin
                latch_or_sel0 <= (next_state == HB8_ADDR);
            end else begin
                latch_or_sel0 <= !((next_state != HB8_IDLE) && !sel_now);
            end
            // Pin 26 is a select only with latch plus two selects
            sel0_alt_n <= (select_latch_config == `HB8_SEL_ALE_TWO_CS) ?
                          !((next_state != HB8_IDLE) && !sel_now) : 1'b0;
            sel1_n     <= sel_has_two(select_latch_config) ?
                          !((next_state != HB8_IDLE) && sel_now) : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_idle_when_off;
        !port_active && !busy |=> rd_n && wr_n && (shared_line_oe == '0);
    endproperty
    a_idle_when_off: assert property (p_idle_when_off) else $error("bus moved while off");

    property p_mux_addr;
        muxed && (state == HB8_ADDR) |-> (shared_line_oe == '1) &&
            (shared_line_out == addr_q[`HB8_LO_W-1:0]);
    endproperty
    a_mux_addr: assert property (p_mux_addr) else $error("address missing on lines");

    property p_hi_addr;
        muxed && (state == HB8_DATA) |-> addr_line == addr_q[`HB8_ADDR_W-1:`HB8_HI_LSB];
    endproperty
    a_hi_addr: assert property (p_hi_addr) else $error("high address wrong");

    property p_latch_closed;
        !rd_n || !wr_n |-> !(sel_has_latch(select_latch_config) && latch_or_sel0);
    endproperty
    a_latch_closed: assert property (p_latch_closed) else $error("latch open at strobe");

    property p_no_overlap;
        !(!rd_n && !wr_n);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("both strobes low");

    property p_one_select;
        (select_latch_config == `HB8_SEL_ONE_CS) && (state == HB8_DATA) && !sel_q
            |-> !latch_or_sel0 && !sel1_n;
    endproperty
    a_one_select: assert property (p_one_select) else $error("select wrong");

    property p_slow_write;
        $fell(wr_n) |-> (!wr_n)[*6] ##1 wr_n;
    endproperty
    a_slow_write: assert property (p_slow_write) else $error("write strobe width");

    property p_nonmux_data;
        !muxed && (state == HB8_DATA) && write_q |-> shared_line_out == wdata_q;
    endproperty
    a_nonmux_data: assert property (p_nonmux_data) else $error("data line wrong");

    property p_order;
        req_valid && req_ready |=> (rd_n && wr_n)[*4] ##1 (!rd_n || !wr_n);
    endproperty
    a_order: assert property (p_order) else $error("strobe before address");

    c_write: cover property (req_valid && req_ready && req_write);
    c_read: cover property ($rose(rsp_valid) && !write_q);
    c_two_sel: cover property (!sel1_n && sel_has_two(select_latch_config));
    c_nonmux: cover property (!muxed && state == HB8_DATA);
endmodule

// ---- hw/hb8_phase_timer.sv ----
/*
 * Phase timer: counts down the length of one bus phase.
 * Assumes load is a single-cycle pulse from the sequencer.
 */
`timescale 1ns/100ps

module hb8_phase_timer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Sequencer side
    hb8_tmr_if.tmr   tmr
);
    import hb8_pkg::*;

    hb8_cnt_t cnt;  // Cycles left in phase

    ////////////////////////////////////////////////////////////////////////
    // Down counter; reload wins over counting
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (tmr.load) begin
            cnt <= tmr.len;
        end else if (cnt != '0) begin
            cnt <= cnt - hb8_cnt_t'(1);
        end
    end

    // Done while the final cycle of a phase runs
    assign tmr.done = (cnt == '0);
endmodule

// ---- hw/hb8_pkg.sv ----
/*
 * Types for the eight_bit_host_bus master.
 * Assumes hb8_consts.svh on the include path.
 */
`include "hb8_consts.svh"

package hb8_pkg;
    // Access sequencer states
    typedef enum logic [2:0] {
        HB8_IDLE,
        HB8_ADDR,
        HB8_LATCH,
        HB8_DATA,
        HB8_RECOV
    } hb8_state_t;

    // Phase counter value
    typedef logic [`HB8_CNT_W-1:0] hb8_cnt_t;
endpackage

// ---- hw/hb8_tmr_if.sv ----
/*
 * Carrier between the access sequencer and its phase timer.
 * Assumes both sides share clk_sys.
 */
`timescale 1ns/100ps

interface hb8_tmr_if;
    import hb8_pkg::*;
    logic     load;   // Start a phase
    hb8_cnt_t len;    // Phase length minus one
    logic     done;   // Last cycle of the phase

    modport ctl (output load, output len, input done);
    modport tmr (input load, input len, output done);
endinterface

// ---- verification/hb8_far_model.sv ----
/*
 * Far side of the host bus: address latch plus one byte-wide peripheral.
 * Assumes the bench resolves the shared lines and feeds the result back.
 */
`timescale 1ns/100ps

module hb8_far_model (
    // Clock and mode
    input  wire logic        clk_sys,
    input  wire logic        muxed,
    input  wire logic [1:0]  cfg,
    input  wire logic        slow,
    // Bus pins
    input  wire logic [7:0]  wire_lo,
    input  wire logic [11:0] addr_line,
    input  wire logic        latch_or_sel0,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    // Answer and latch contents
    output logic [7:0]       drive,
    output logic [7:0]       latched
);
    logic [7:0] mem [256]; // Peripheral store
    logic [7:0] last;      // Last resolved line value
    logic       ale;       // Latch transparent
    logic       rd_age;    // Read strobe seen for a cycle
    logic [7:0] idx;       // Location addressed

    ////////////////////////////////////////////////////////////////////////
    // Without a latch pin the latch is open while no data strobe is low
    assign ale = (cfg == 2'h0 || cfg == 2'h3) ? latch_or_sel0 : (rd_n & wr_n);
    assign idx = muxed ? latched : addr_line[7:0];

    // Latch keeps the address through the data phase
    always @(posedge clk_sys) begin
        last <= wire_lo;
        rd_age <= ~rd_n;
        if (ale) begin
            latched <= wire_lo;
        end
        if (!wr_n) begin
            mem[idx] <= wire_lo;
        end
    end

    // Released lines show the inverse of the last value, never a stale copy
    always_comb begin
        if (!rd_n && (!slow || rd_age)) begin
            drive = mem[idx];
        end else begin
            drive = ~last;
        end
    end
endmodule

// ---- verification/host_bus8_muxed_addr_data_tb.sv ----
/*
 * Self-checking bench for hb8_mux_bus with a far-side model.
 * Assumes default phase lengths 3/6/2 cycles and a 125 MHz clock.
 */
`timescale 1ns/100ps
`include "hb8_consts.svh"

module host_bus8_muxed_addr_data_tb;
    logic        clk_sys, rst_n, req_valid, req_ready, req_write, req_sel;
    logic [3:0]  port_mode;
    logic [1:0]  host_bus_mode, select_latch_config;
    logic [19:0] req_addr;
    logic [7:0]  req_wdata, rsp_rdata, shared_line_out, shared_line_oe, drive, latched;
    logic [7:0]  wire_lo;
    logic [11:0] addr_line;
    logic        rsp_valid, latch_or_sel0, sel0_alt_n, sel1_n, rd_n, wr_n, slow;
    logic [8:0]  exp_q [$];  // Pending answers: read flag and data
    logic [7:0]  model [256]; // Expected peripheral contents
    int          num_errors, num_checks;

    // Resolved shared lines
    assign wire_lo = (shared_line_oe & shared_line_out) | (~shared_line_oe & drive);

    hb8_mux_bus hb8_mux_bus_i (.clk_sys(clk_sys), .rst_n(rst_n), .port_mode(port_mode),
        .host_bus_mode(host_bus_mode), .select_latch_config(select_latch_config),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
        .req_sel(req_sel), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .shared_line_in(wire_lo),
        .shared_line_out(shared_line_out), .shared_line_oe(shared_line_oe),
        .addr_line(addr_line), .latch_or_sel0(latch_or_sel0), .sel0_alt_n(sel0_alt_n),
        .sel1_n(sel1_n), .rd_n(rd_n), .wr_n(wr_n));

    hb8_far_model hb8_far_model_i (.clk_sys(clk_sys), .muxed(host_bus_mode == 2'h0),
        .cfg(select_latch_config), .slow(slow), .wire_lo(wire_lo), .addr_line(addr_line),
        .latch_or_sel0(latch_or_sel0), .rd_n(rd_n), .wr_n(wr_n), .drive(drive),
        .latched(latched));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One access, checked phase by phase against the hand-over timing
    task automatic access(input logic wr, input logic s, input logic [19:0] a,
                          input logic [7:0] d);
        int  n;
        logic [1:0] c;
        logic lat;
        n = 0;
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 40) begin
            chk("ready_wait", 1, 0);
            finish_test();
        end
        @(posedge clk_sys);
        // Read the select option only after a config change has settled
        c = select_latch_config;
        req_valid <= 1'b1;
        req_write <= wr;
        req_sel <= s;
        req_addr <= a;
        req_wdata <= d;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        exp_q.push_back({~wr, wr ? 8'h00 : model[a[7:0]]});
        if (wr) begin
            model[a[7:0]] = d;
        end
        for (int k = 0; k < 14; k++) begin
            @(negedge clk_sys);
            lat = (c == 2'h0 || c == 2'h3) ? (k < 3) : s;
            if (k == 0 || k == 2 || k == 7) begin
                chk("selects", {lat, c == 2'h3 && s, c[1] && !s},
                    {latch_or_sel0, sel0_alt_n, sel1_n});
            end
            if (k == 2 && host_bus_mode == 2'h0) begin
                chk("addr_phase", {a[7:0], 8'hFF}, {wire_lo, shared_line_oe});
                chk("addr_hi", a[19:8], addr_line);
            end
            if (k == 2 && host_bus_mode == 2'h1) begin
                chk("addr_ded", a[11:0], addr_line);
            end
            if (k == 7) begin
                chk("strobes", {rd_n, wr_n}, {wr, ~wr});
                chk("data_oe", {8{wr}}, shared_line_oe);
                if (wr) begin
                    chk("data_phase", d, wire_lo);
                end
                if (host_bus_mode == 2'h0) begin
                    chk("latch_hold", a[7:0], latched);
                end
            end
            if (k == 3) begin
                chk("strobe_late", 2'b11, {rd_n, wr_n});
            end
            if (k >= 10) begin
                chk("answer_time", {k == 10, k >= 12}, {rsp_valid, req_ready});
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Read answers are compared in order as they appear; write answers are only popped
    always @(negedge clk_sys) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("stray_answer", 0, 1);
            end else if (exp_q[0][8]) begin
                chk("rdata", exp_q[0][7:0], rsp_rdata);
                void'(exp_q.pop_front());
            end else begin
                void'(exp_q.pop_front());
            end
        end
    end

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        finish_test();
    end

    initial begin
        logic [19:0] a [2];
        logic [3:0]  bad_pm [4];
        logic [1:0]  bad_hm [4];
        {rst_n, req_valid, req_write, req_sel, req_addr, req_wdata, slow} = '0;
        {host_bus_mode, select_latch_config} = '0;
        port_mode = `HB8_PORT_MODE_HB8;
        bad_pm = '{4'h1, 4'h0, 4'h2, 4'h2};
        bad_hm = '{2'h0, 2'h0, 2'h2, 2'h3};
        void'($urandom(73));
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("reset_pins", {rd_n, wr_n, rsp_valid, shared_line_oe}, 11'h600);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        // Both variants, every select option, both peripherals, prompt and slow
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 4; c++) begin
                for (int s = 0; s < 2; s++) begin
                    @(posedge clk_sys);
                    host_bus_mode <= 2'(m);
                    select_latch_config <= 2'(c);
                    slow <= 1'(c);
                    for (int j = 0; j < 2; j++) begin
                        a[j] = 20'($urandom);
                        a[j][7:0] = {1'(m), 2'(c), 1'(s), 3'($urandom), 1'(j)};
                        access(1'b1, 1'(s), a[j], 8'($urandom));
                    end
                    access(1'b0, 1'(s), a[1], 8'h00);
                    access(1'b0, 1'(s), a[0], 8'h00);
                end
            end
        end
        $display("Test access modes done");
        // Any other mode pair refuses requests
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            port_mode <= bad_pm[i];
            host_bus_mode <= bad_hm[i];
            req_valid <= 1'b1;
            repeat (15) @(negedge clk_sys);
            chk("refused", 0, req_ready);
            @(posedge clk_sys);
            req_valid <= 1'b0;
            @(posedge clk_sys);
            port_mode <= `HB8_PORT_MODE_HB8;
            host_bus_mode <= `HB8_HB_MODE_MUXED;
        end
        $display("Test refusal done");
        repeat (3) @(posedge clk_sys);
        chk("queue_empty", 0, exp_q.size());
        finish_test();
    end
endmodule
